// >>> bfuh_nvm_model.sv
// journalled nonvolatile memory model that stands behind the handler's memory port
`include "bfuh_params.svh"
module bfuh_nvm_model (
    input  wire logic                sys_clk,
    input  wire bfuh_pkg::bfuh_nvm_t nvmReq,
    input  wire logic                failOn,
    input  wire logic                slow,
    output logic                     nvmReady,
    output logic                     nvmFail
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]   mem [8][256] = '{default: '0};
    logic [7:0]   stage [256];
    logic [255:0] dirty = '0;
    logic         tick = 1'b0;
    int           ops = 0;
    // --------------------------------
    // accept and journal
    // --------------------------------
    assign nvmReady = nvmReq.valid & (~slow | tick);
    // fail line is noise while nothing is taken, so a stale level cannot pass for an answer
    assign nvmFail = nvmReady ? failOn & (nvmReq.op == `BFUH_OP_COMMIT) : tick;
    always @(posedge sys_clk) begin
        tick <= ~tick;
        if (nvmReady) begin
            ops++;
            if (nvmReq.op == `BFUH_OP_BEGIN) dirty <= '0;
            if (nvmReq.op == `BFUH_OP_WRITE) begin
                stage[nvmReq.addr[7:0]] <= nvmReq.data;
                dirty[nvmReq.addr[7:0]] <= 1'b1;
            end
            // a failed or missing commit leaves the file as it was
            if (nvmReq.op == `BFUH_OP_COMMIT && !nvmFail) begin
                for (int i = 0; i < 256; i++) if (dirty[i]) mem[nvmReq.fileIdx][i] <= stage[i];
            end
        end
    end
endmodule

// >>> bfuh_params.svh
// offsets, field values, status words and codes of the binary update handler
`ifndef BFUH_PARAMS_SVH
`define BFUH_PARAMS_SVH
`define BFUH_A_HDR      8'h00
`define BFUH_A_LEN      8'h04
`define BFUH_A_CTRL     8'h08
`define BFUH_A_DATA     8'h0C
`define BFUH_A_STAT     8'h10
`define BFUH_A_SESS     8'h14
`define BFUH_A_FTAB     8'h20
`define BFUH_NFILES     8
`define BFUH_CLA        8'h00
`define BFUH_INS        8'hD6
`define BFUH_SFI_CUR    5'h00
`define BFUH_SFI_RSVD   5'h1F
`define BFUH_AR_FREE    4'hE
`define BFUH_HDR_LEN    9'h005
`define BFUH_SW_OK      16'h9000
`define BFUH_SW_MEMFAIL 16'h6581
`define BFUH_SW_BADLEN  16'h6700
`define BFUH_SW_SECURE  16'h6982
`define BFUH_SW_COND    16'h6985
`define BFUH_SW_NOFILE  16'h6A82
`define BFUH_SW_PARAMS  16'h6A86
`define BFUH_SW_CLASS   16'h6E00
`define BFUH_OP_BEGIN   2'h1
`define BFUH_OP_WRITE   2'h2
`define BFUH_OP_COMMIT  2'h3
`define BFUH_RESP_OKAY  2'h0
`define BFUH_RESP_SLVERR 2'h2
`define BFUH_STAT_RST   16'h0000
`endif

// >>> bfuh_pkg.sv
// types of the binary update handler
package bfuh_pkg;
    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_CHECK  = 3'b001,
        S_BEGIN  = 3'b010,
        S_WAIT   = 3'b011,
        S_WRITE  = 3'b100,
        S_COMMIT = 3'b101
    } bfuh_state_t;

    typedef struct packed {
        logic        present;
        logic        stdData;
        logic [4:0]  sfi;
        logic [3:0]  wrRight;
        logic [3:0]  rwRight;
        logic        rsvd;
        logic [15:0] size;
    } bfuh_file_t;

    typedef struct packed {
        logic [22:0] rsvd;
        logic        plainMode;
        logic        tmacPresent;
        logic        chainBusy;
        logic        lrpAuth;
        logic        aesAuth;
        logic [2:0]  selIdx;
        logic        selValid;
    } bfuh_sess_t;

    typedef struct packed {
        logic        valid;
        logic [1:0]  op;
        logic [2:0]  fileIdx;
        logic [14:0] addr;
        logic [7:0]  data;
    } bfuh_nvm_t;
endpackage

// >>> bfuh_update_handler.sv
// update-binary command interpreter with AXI4-Lite registers and a journalled NV port
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`include "bfuh_params.svh"

module bfuh_update_handler (
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    input  wire logic               ce,
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    output bfuh_pkg::bfuh_nvm_t     nvmReq,
    input  wire logic               nvmReady,
    input  wire logic               nvmFail,
    output logic [15:0]             statusWord,
    output logic                    cmdDone
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'b00) && (a <= `BFUH_A_SESS ||
                 (a >= `BFUH_A_FTAB && a < `BFUH_A_FTAB + 8'(4 * `BFUH_NFILES)));
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        for (int b = 0; b < 4; b++) begin
            merge[8*b +: 8] = s[b] ? n[8*b +: 8] : o[8*b +: 8];
        end
    endfunction

    function automatic logic isFree(input logic [3:0] ar);
        isFree = (ar == `BFUH_AR_FREE);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    bfuh_pkg::bfuh_state_t stateReg, stateNext;
    bfuh_pkg::bfuh_file_t  ftabReg [`BFUH_NFILES];
    bfuh_pkg::bfuh_file_t  ftabNext [`BFUH_NFILES];
    bfuh_pkg::bfuh_sess_t  sessReg, sessNext;
    bfuh_pkg::bfuh_nvm_t   nvmReg, nvmNext;
    logic [31:0] hdrReg, hdrNext;
    logic [31:0] lenReg, lenNext;
    logic [15:0] swReg, swNext;
    logic        doneReg, doneNext;
    logic [14:0] offReg, offNext;
    logic [2:0]  tgtReg, tgtNext;
    logic [7:0]  cntReg, cntNext;
    logic        awHeldReg, awHeldNext, wHeldReg, wHeldNext;
    logic [7:0]  awAddrReg, awAddrNext;
    logic [31:0] wDataReg, wDataNext, rDataReg, rDataNext;
    logic [3:0]  wStrbReg, wStrbNext;
    logic        awRdyReg, wRdyReg, arRdyReg, bValReg, rValReg;
    logic        bValNext, rValNext;
    logic [1:0]  bRespReg, bRespNext, rRespReg, rRespNext;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic [7:0]  cla, ins, p1, p2, lc;
    logic [8:0]  apduLen;
    logic        sfiMode, bySfi, tgtFound, start;
    logic [4:0]  sfi;
    logic [14:0] offset;
    logic [2:0]  hitIdx, tgtIdx;
    logic [`BFUH_NFILES-1:0] hit;
    logic [15:0] chkSw;
    bfuh_pkg::bfuh_file_t tgt;

    assign cla     = hdrReg[31:24];
    assign ins     = hdrReg[23:16];
    assign p1      = hdrReg[15:8];
    assign p2      = hdrReg[7:0];
    assign lc      = lenReg[7:0];
    assign apduLen = lenReg[16:8];
    assign sfiMode = p1[7];
    assign sfi     = p1[4:0];
    assign bySfi   = sfiMode && (sfi != `BFUH_SFI_CUR);
    assign offset  = sfiMode ? {7'h00, p2} : {p1[6:0], p2};

    genvar gi;
    generate
        for (gi = 0; gi < `BFUH_NFILES; gi++) begin : g_hit
            assign hit[gi] = ftabReg[gi].present && (ftabReg[gi].sfi == sfi);
        end
    endgenerate

    always_comb begin
        hitIdx = 3'h0;
        for (int i = `BFUH_NFILES - 1; i >= 0; i--) begin
            if (hit[i]) begin
                hitIdx = 3'(i);
            end
        end
    end

    // id 00h keeps the selection, other ids address by lookup
    assign tgtIdx   = bySfi ? hitIdx : sessReg.selIdx;
    assign tgt      = ftabReg[tgtIdx];
    assign tgtFound = bySfi ? (|hit) : tgt.present;

    // first failing check decides the word; order mirrors reader expectations
    always_comb begin
        if (cla != `BFUH_CLA || ins != `BFUH_INS) begin
            chkSw = `BFUH_SW_CLASS;
        end else if (lc == 8'h00 || apduLen != 9'(`BFUH_HDR_LEN + {1'b0, lc})) begin
            chkSw = `BFUH_SW_BADLEN;
        end else if (sfiMode && (p1[6:5] != 2'b00 || sfi == `BFUH_SFI_RSVD)) begin
            chkSw = `BFUH_SW_PARAMS;
        end else if (sessReg.chainBusy || (!bySfi && !sessReg.selValid)) begin
            chkSw = `BFUH_SW_COND;
        end else if (!tgtFound) begin
            chkSw = `BFUH_SW_NOFILE;
        end else if (!tgt.stdData) begin
            chkSw = `BFUH_SW_COND;
        end else if (sessReg.tmacPresent) begin
            chkSw = `BFUH_SW_COND;
        end else if (sessReg.aesAuth || sessReg.lrpAuth || !sessReg.plainMode) begin
            chkSw = `BFUH_SW_SECURE;
        end else if (!isFree(tgt.wrRight) && !isFree(tgt.rwRight)) begin
            chkSw = `BFUH_SW_SECURE;
        end else if (16'({1'b0, offset} + {8'h00, lc}) > tgt.size) begin
            chkSw = `BFUH_SW_COND;
        end else begin
            chkSw = `BFUH_SW_OK;
        end
    end

    // ------------------------------------------------------------
    // next state: bus slave and command sequencer
    // ------------------------------------------------------------
    logic wrDo, rdDo;
    assign wrDo = awHeldReg && wHeldReg && !bValReg;
    assign rdDo = s_axi_arvalid && arRdyReg;
    assign start = wrDo && awAddrReg == `BFUH_A_CTRL && wStrbReg[0] && wDataReg[0];

    always_comb begin
        stateNext  = stateReg;
        ftabNext   = ftabReg;
        sessNext   = sessReg;
        nvmNext    = nvmReg;
        hdrNext    = hdrReg;
        lenNext    = lenReg;
        swNext     = swReg;
        doneNext   = doneReg;
        offNext    = offReg;
        tgtNext    = tgtReg;
        cntNext    = cntReg;
        awHeldNext = awHeldReg;
        wHeldNext  = wHeldReg;
        awAddrNext = awAddrReg;
        wDataNext  = wDataReg;
        wStrbNext  = wStrbReg;
        bValNext   = bValReg;
        bRespNext  = bRespReg;
        rValNext   = rValReg;
        rRespNext  = rRespReg;
        rDataNext  = rDataReg;

        if (s_axi_awvalid && awRdyReg) begin
            awHeldNext = 1'b1;
            awAddrNext = s_axi_awaddr;
        end
        if (s_axi_wvalid && wRdyReg) begin
            wHeldNext = 1'b1;
            wDataNext = s_axi_wdata;
            wStrbNext = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bValNext = 1'b0;
        end
        // header and table stay frozen while a command runs
        if (wrDo) begin
            awHeldNext = 1'b0;
            wHeldNext  = 1'b0;
            bValNext   = 1'b1;
            bRespNext  = mapped(awAddrReg) ? `BFUH_RESP_OKAY : `BFUH_RESP_SLVERR;
            if (stateReg == bfuh_pkg::S_IDLE) begin
                case (awAddrReg)
                    `BFUH_A_HDR:  hdrNext  = merge(hdrReg, wDataReg, wStrbReg);
                    `BFUH_A_LEN:  lenNext  = merge(lenReg, wDataReg, wStrbReg);
                    `BFUH_A_SESS: sessNext = merge(sessReg, wDataReg, wStrbReg);
                    default: begin
                        for (int i = 0; i < `BFUH_NFILES; i++) begin
                            if (awAddrReg == `BFUH_A_FTAB + 8'(4 * i)) begin
                                ftabNext[i] = merge(ftabReg[i], wDataReg, wStrbReg);
                            end
                        end
                    end
                endcase
            end
        end
        if (s_axi_rvalid && s_axi_rready) begin
            rValNext = 1'b0;
        end
        if (rdDo) begin
            rValNext  = 1'b1;
            rRespNext = mapped(s_axi_araddr) ? `BFUH_RESP_OKAY : `BFUH_RESP_SLVERR;
            case (s_axi_araddr)
                `BFUH_A_HDR:  rDataNext = hdrReg;
                `BFUH_A_LEN:  rDataNext = {15'h0000, lenReg[16:0]};
                `BFUH_A_STAT: rDataNext = {swReg, 3'h0, cntReg, stateReg,
                                           stateReg == bfuh_pkg::S_WAIT, doneReg};
                `BFUH_A_SESS: rDataNext = sessReg;
                default: begin
                    rDataNext = 32'h0000_0000;
                    for (int i = 0; i < `BFUH_NFILES; i++) begin
                        if (s_axi_araddr == `BFUH_A_FTAB + 8'(4 * i)) begin
                            rDataNext = ftabReg[i];
                        end
                    end
                end
            endcase
        end

        case (stateReg)
            bfuh_pkg::S_IDLE: begin
                if (start) begin
                    doneNext  = 1'b0;
                    stateNext = bfuh_pkg::S_CHECK;
                end
            end
            bfuh_pkg::S_CHECK: begin
                // nothing reaches the memory port unless every check passed
                if (chkSw != `BFUH_SW_OK) begin
                    swNext    = chkSw;
                    doneNext  = 1'b1;
                    stateNext = bfuh_pkg::S_IDLE;
                end else begin
                    offNext   = offset;
                    tgtNext   = tgtIdx;
                    cntNext   = 8'h00;
                    sessNext.selValid = 1'b1;
                    sessNext.selIdx   = tgtIdx;
                    nvmNext   = '{1'b1, `BFUH_OP_BEGIN, tgtIdx, offset, 8'h00};
                    stateNext = bfuh_pkg::S_BEGIN;
                end
            end
            bfuh_pkg::S_WAIT: begin
                if (wrDo && awAddrReg == `BFUH_A_DATA) begin
                    nvmNext = '{1'b1, `BFUH_OP_WRITE, tgtReg,
                                15'(offReg + {7'h00, cntReg}), wDataReg[7:0]};
                    stateNext = bfuh_pkg::S_WRITE;
                end
            end
            bfuh_pkg::S_BEGIN, bfuh_pkg::S_WRITE, bfuh_pkg::S_COMMIT: begin
                if (nvmReady) begin
                    nvmNext.valid = 1'b0;
                    if (nvmFail) begin
                        // uncommitted journal is dropped by the memory side
                        swNext    = `BFUH_SW_MEMFAIL;
                        doneNext  = 1'b1;
                        stateNext = bfuh_pkg::S_IDLE;
                    end else if (stateReg == bfuh_pkg::S_BEGIN) begin
                        stateNext = bfuh_pkg::S_WAIT;
                    end else if (stateReg == bfuh_pkg::S_COMMIT) begin
                        swNext    = `BFUH_SW_OK;
                        doneNext  = 1'b1;
                        stateNext = bfuh_pkg::S_IDLE;
                    end else begin
                        cntNext = 8'(cntReg + 8'h01);
                        if (8'(cntReg + 8'h01) == lc) begin
                            // one commit per frame; a command sent while a chain is busy is refused at the check and never gets here
                            nvmNext = '{1'b1, `BFUH_OP_COMMIT, tgtReg, offReg, 8'h00};
                            stateNext = bfuh_pkg::S_COMMIT;
                        end else begin
                            stateNext = bfuh_pkg::S_WAIT;
                        end
                    end
                end
            end
            default: stateNext = bfuh_pkg::S_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            stateReg  <= bfuh_pkg::S_IDLE;
            ftabReg   <= '{default: '0};
            sessReg   <= '0;
            nvmReg    <= '0;
            hdrReg    <= 32'h0000_0000;
            lenReg    <= 32'h0000_0000;
            swReg     <= `BFUH_STAT_RST;
            doneReg   <= 1'b0;
            offReg    <= 15'h0000;
            tgtReg    <= 3'h0;
            cntReg    <= 8'h00;
            awHeldReg <= 1'b0;
            wHeldReg  <= 1'b0;
            awAddrReg <= 8'h00;
            wDataReg  <= 32'h0000_0000;
            wStrbReg  <= 4'h0;
            awRdyReg  <= 1'b0;
            wRdyReg   <= 1'b0;
            arRdyReg  <= 1'b0;
            bValReg   <= 1'b0;
            bRespReg  <= 2'h0;
            rValReg   <= 1'b0;
            rRespReg  <= 2'h0;
            rDataReg  <= 32'h0000_0000;
        end else if (ce) begin
            stateReg  <= stateNext;
            ftabReg   <= ftabNext;
            sessReg   <= sessNext;
            nvmReg    <= nvmNext;
            hdrReg    <= hdrNext;
            lenReg    <= lenNext;
            swReg     <= swNext;
            doneReg   <= doneNext;
            offReg    <= offNext;
            tgtReg    <= tgtNext;
            cntReg    <= cntNext;
            awHeldReg <= awHeldNext;
            wHeldReg  <= wHeldNext;
            awAddrReg <= awAddrNext;
            wDataReg  <= wDataNext;
            wStrbReg  <= wStrbNext;
            awRdyReg  <= !awHeldNext;
            wRdyReg   <= !wHeldNext;
            arRdyReg  <= !rValNext;
            bValReg   <= bValNext;
            bRespReg  <= bRespNext;
            rValReg   <= rValNext;
            rRespReg  <= rRespNext;
            rDataReg  <= rDataNext;
        end
    end

    assign s_axi_awready = awRdyReg;
    assign s_axi_wready  = wRdyReg;
    assign s_axi_bvalid  = bValReg;
    assign s_axi_bresp   = bRespReg;
    assign s_axi_arready = arRdyReg;
    assign s_axi_rvalid  = rValReg;
    assign s_axi_rresp   = rRespReg;
    assign s_axi_rdata   = rDataReg;
    assign nvmReq        = nvmReg;
    assign statusWord    = swReg;
    assign cmdDone       = doneReg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_BAD_CLASS: assert property (
        ce && stateReg == bfuh_pkg::S_CHECK && cla != `BFUH_CLA
        |=> swReg == `BFUH_SW_CLASS && doneReg && stateReg == bfuh_pkg::S_IDLE)
        else $error("wrong class not answered with 6E00");
    AST_BAD_LENGTH: assert property (
        ce && stateReg == bfuh_pkg::S_CHECK && cla == `BFUH_CLA && ins == `BFUH_INS
        && lc == 8'h00 |=> swReg == `BFUH_SW_BADLEN)
        else $error("zero length not answered with 6700");
    AST_BAD_PARAMS: assert property (
        ce && stateReg == bfuh_pkg::S_CHECK && chkSw != `BFUH_SW_CLASS
        && chkSw != `BFUH_SW_BADLEN && sfiMode && sfi == `BFUH_SFI_RSVD
        |=> swReg == `BFUH_SW_PARAMS)
        else $error("reserved short id not answered with 6A86");
    AST_ERROR_NO_NVM: assert property (
        ce && stateReg == bfuh_pkg::S_CHECK && chkSw != `BFUH_SW_OK
        |=> !nvmReg.valid [*2])
        else $error("memory touched after failed check");
    AST_COMMIT_FULL: assert property (
        nvmReg.valid && nvmReg.op == `BFUH_OP_COMMIT |-> cntReg == lc)
        else $error("commit before all frame bytes written");
    AST_FIRST_ADDR: assert property (
        nvmReg.valid && nvmReg.op == `BFUH_OP_WRITE && cntReg == 8'h00
        |-> nvmReg.addr == offset)
        else $error("first write not at decoded offset");
    AST_SUCCESS_WORD: assert property (
        ce && stateReg == bfuh_pkg::S_COMMIT && nvmReady && !nvmFail
        |=> swReg == `BFUH_SW_OK && doneReg)
        else $error("commit not answered with 9000");
    AST_MEM_FAIL: assert property (
        ce && nvmReg.valid && nvmReady && nvmFail
        |=> swReg == `BFUH_SW_MEMFAIL && stateReg == bfuh_pkg::S_IDLE)
        else $error("memory failure not answered with 6581");
    AST_CHAIN_BUSY: assert property (
        ce && stateReg == bfuh_pkg::S_CHECK && sessReg.chainBusy
        |=> swReg != `BFUH_SW_OK && !nvmReg.valid)
        else $error("command accepted during chain");

    COV_SUCCESS: cover property (ce && stateReg == bfuh_pkg::S_COMMIT && nvmReady && !nvmFail);
    COV_MEMFAIL: cover property (ce && nvmReg.valid && nvmReady && nvmFail);
    COV_CLASS:   cover property (ce && stateReg == bfuh_pkg::S_CHECK && chkSw == `BFUH_SW_CLASS);
endmodule

// >>> bfuh_update_handler_bench.sv
// self-checking bench of the binary update handler
`include "bfuh_params.svh"
module bfuh_update_handler_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                sys_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, failOn = 1'b0, slow = 1'b0;
    logic [7:0]          s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0]         s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]          s_axi_wstrb = 4'hF;
    logic                s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic                s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic                s_axi_bvalid, s_axi_arready, s_axi_rvalid, nvmReady, nvmFail, cmdDone;
    logic [1:0]          s_axi_bresp, s_axi_rresp;
    logic [15:0]         statusWord;
    bfuh_pkg::bfuh_nvm_t nvmReq;
    logic                prevDone = 1'b0;
    logic [15:0]         expQ[$];
    logic [7:0]          dataQ[$];
    int                  miscompares = 0, nCompared = 0, doneCnt = 0, seed = 32'h301D0766;
    // {header, length, session, status}
    logic [75:0] tab [16] = '{
        {32'h01D68100, 16'h0601, 12'h100, 16'h6E00}, {32'h00B08100, 16'h0601, 12'h100, 16'h6E00},
        {32'h00D68100, 16'h0701, 12'h100, 16'h6700}, {32'h00D68100, 16'h0500, 12'h100, 16'h6700},
        {32'h00D69F00, 16'h0601, 12'h100, 16'h6A86}, {32'h00D6A100, 16'h0601, 12'h100, 16'h6A86},
        {32'h00D68000, 16'h0601, 12'h100, 16'h6985}, {32'h00D68400, 16'h0601, 12'h100, 16'h6A82},
        {32'h00D68200, 16'h0601, 12'h100, 16'h6985}, {32'h00D68100, 16'h0601, 12'h180, 16'h6985},
        {32'h00D68100, 16'h0601, 12'h140, 16'h6985}, {32'h00D68100, 16'h0601, 12'h110, 16'h6982},
        {32'h00D68100, 16'h0601, 12'h120, 16'h6982}, {32'h00D68100, 16'h0601, 12'h000, 16'h6982},
        {32'h00D68300, 16'h0601, 12'h100, 16'h6982}, {32'h00D6810F, 16'h0702, 12'h100, 16'h6985}};
    logic [31:0] ftab [3] = '{32'hC3DE0010, 32'h85DE0010, 32'hC7FE0010};

    bfuh_update_handler uut (.sys_clk, .rst_n, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .nvmReq, .nvmReady, .nvmFail, .statusWord, .cmdDone);
    bfuh_nvm_model nvm (.sys_clk, .nvmReq, .failOn, .slow, .nvmReady, .nvmFail);

    always #2.5 sys_clk = ~sys_clk;

    // --------------------------------
    // checking and closing
    // --------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("compared %0d, mismatched %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        prevDone <= cmdDone;
        if (rst_n && cmdDone === 1'b1 && prevDone !== 1'b1) begin
            doneCnt++;
            check(statusWord, expQ.size() ? expQ.pop_front() : 16'hXXXX);
        end
    end
    initial begin
        #50000;
        miscompares++;
        conclude();
    end

    // --------------------------------
    // bus and command tasks
    // --------------------------------
    // waits end only at the answer; a hang is left to the watchdog
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // single-frame command: header, length, start, then one data byte per request
    task automatic runCmd(input logic [31:0] hdr, input logic [31:0] len,
                          input logic [15:0] exp, input int nb);
        logic [31:0] r;
        logic [1:0]  rr;
        int          base;
        axiWrite(`BFUH_A_HDR, hdr, rr);
        axiWrite(`BFUH_A_LEN, len, rr);
        expQ.push_back(exp);
        base = doneCnt;
        axiWrite(`BFUH_A_CTRL, 32'h00000001, rr);
        for (int n = 0; n < nb; n++) begin
            do begin
                axiRead(`BFUH_A_STAT, r, rr);
            end while (r[1] !== 1'b1);
            r = $random(seed);
            dataQ.push_back(r[7:0]);
            axiWrite(`BFUH_A_DATA, {24'h000000, r[7:0]}, rr);
        end
        while (doneCnt == base) begin
            @(posedge sys_clk);
        end
    endtask

    initial begin
        logic [31:0] r;
        logic [1:0]  rr;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        axiRead(`BFUH_A_STAT, r, rr);
        check(r, 32'h00000000);
        axiRead(8'h1C, r, rr);
        check(rr, `BFUH_RESP_SLVERR);
        axiWrite(8'h1C, 32'h00000000, rr);
        check(rr, `BFUH_RESP_SLVERR);
        for (int i = 0; i < 3; i++) axiWrite(8'(`BFUH_A_FTAB + 4 * i), ftab[i], rr);
        for (int i = 0; i < 16; i++) begin
            axiWrite(`BFUH_A_SESS, {20'h00000, tab[i][27:16]}, rr);
            runCmd(tab[i][75:44], {16'h0000, tab[i][43:28]}, tab[i][15:0], 0);
        end
        check(nvm.ops, 0);
        axiWrite(`BFUH_A_SESS, 32'h00000100, rr);
        slow <= 1'b1;
        runCmd(32'h00D6810E, 32'h00000702, `BFUH_SW_OK, 2);
        for (int k = 0; k < 2; k++) check(nvm.mem[0][14 + k], dataQ.pop_front());
        slow <= 1'b0;
        runCmd(32'h00D60003, 32'h00000601, `BFUH_SW_OK, 1);
        check(nvm.mem[0][3], dataQ.pop_front());
        failOn <= 1'b1;
        runCmd(32'h00D68100, 32'h00000601, `BFUH_SW_MEMFAIL, 1);
        check(nvm.mem[0][0], 8'h00);
        conclude();
    end
endmodule
